//--- logic/pmc_pkg.sv
// package: constants and types for the power mode controller
//
// Operation
// - sleep instruction while running moves to a halted mode picked by control bits
// - accepted interrupt leaves any halted mode back to a running mode
// - direct switch between full-speed and low-speed running without halting
// - direct transition to the same running mode is accepted to apply new frequency
// - low external reset forces reset state from any mode
// - bits all zero: sleep mode; wake to low-speed if selected else full-speed
// - subsleep select alone: subsleep mode; wake per low-speed select
// - standby select without direct bit: standby mode; wake always full-speed
// - direct bit, no subsleep, no low-speed: direct move to full-speed
// - direct bit with low-speed select: direct move to low-speed
// - transition with subsleep select resets timer, serial port, converter
// - main oscillator runs only in full-speed, sleep and reset, and while standby exit settles; subclock always runs
// - standby floats port drivers keeping registers; sleep and subsleep hold ports
// - low-power modes: timebase counts only if timekeeping selected
// - low-speed and subsleep: capture timer holds, or counts subclock if clock-sourced
// - low-power modes: watchdog holds unless internal oscillator is its source
// - retained peripheral registers stay accessible in low-speed mode
// - no wake while interrupt mask set or request disabled
// - standby exit restarts main oscillator and waits settle time first
package pmc_pkg;

   // ----------------------------------------------------------------
   // modes
   // ----------------------------------------------------------------
   typedef enum logic [5:0] {
      PMC_RESET     = 6'h01,
      PMC_ACTIVE    = 6'h02,
      PMC_SLEEP     = 6'h04,
      PMC_SUBACTIVE = 6'h08,
      PMC_SUBSLEEP  = 6'h10,
      PMC_STANDBY   = 6'h20
   } pmc_mode_type;

   // ----------------------------------------------------------------
   // control bits and per-mode gates
   // ----------------------------------------------------------------
   typedef struct packed {
      logic direct_transition_sel;
      logic standby_sel;
      logic subsleep_sel;
      logic low_speed_sel;
   } pmc_ctrl_type;

   typedef struct packed {
      logic main_osc_en;
      logic sub_osc_en;
      logic cpu_run;
      logic ram_access;
      logic port_hold;
      logic port_hiz;
      logic periph_reset;
      logic timebase_en;
      logic capture_en;
      logic capture_on_sub;
      logic watchdog_en;
      logic retained_access;
      logic irq_inputs_live;
   } pmc_gate_type;

   localparam int PMC_IRQ_W    = 4;
   localparam int PMC_WKP_W    = 6;
   localparam int PMC_SETTLE_W = 3;
   localparam int PMC_CNT_W    = 17;

   // settle wait in states per select code; code 7 is shortest
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_0 = 17'h02000;
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_1 = 17'h04000;
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_2 = 17'h08000;
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_3 = 17'h10000;
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_4 = 17'h00100;
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_5 = 17'h00040;
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_6 = 17'h00010;
   localparam logic [PMC_CNT_W-1:0] PMC_SETTLE_7 = 17'h00004;

endpackage

//--- logic/pmc_settle_timer.sv
// settle timer: counts the oscillator settling wait before wake completes
module pmc_settle_timer
   import pmc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    start,
   input  wire logic [PMC_SETTLE_W-1:0] settle_time_sel,
   output logic                         busy,
   output logic                         done
);

   logic [PMC_CNT_W-1:0] cnt_ff;
   logic [PMC_CNT_W-1:0] nxt_cnt;
   logic                 done_ff;
   logic                 nxt_done;
   logic [PMC_CNT_W-1:0] load_val;

   always_comb begin
      unique case (settle_time_sel)
         3'h0: load_val = PMC_SETTLE_0;
         3'h1: load_val = PMC_SETTLE_1;
         3'h2: load_val = PMC_SETTLE_2;
         3'h3: load_val = PMC_SETTLE_3;
         3'h4: load_val = PMC_SETTLE_4;
         3'h5: load_val = PMC_SETTLE_5;
         3'h6: load_val = PMC_SETTLE_6;
         3'h7: load_val = PMC_SETTLE_7;
      endcase
   end

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_done = 1'b0;
      if (start) begin
         nxt_cnt = load_val;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 17'h00001;
         if (cnt_ff == 17'h00001) begin
            nxt_done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_ff  <= '0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         done_ff <= nxt_done;
      end
   end

   assign busy = (cnt_ff != '0);
   assign done = done_ff;

endmodule

//--- logic/pmc_top.sv
// power mode controller: sleep decode, wake, direct transitions, per-mode gating
module pmc_top
   import pmc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    srst,
   input  wire logic                    ext_reset_n,
   input  wire logic                    sleep_exec,
   input  wire pmc_ctrl_type            ctrl,
   input  wire logic [PMC_SETTLE_W-1:0] settle_time_sel,
   input  wire logic                    irq_mask,
   input  wire logic                    irq_pending,
   input  wire logic                    direct_irq_en,
   input  wire logic [PMC_IRQ_W-1:0]    ext_irq_inputs,
   input  wire logic [PMC_WKP_W-1:0]    wakeup_inputs,
   input  wire logic                    timebase_timekeep_sel,
   input  wire logic                    capture_src_sys,
   input  wire logic                    watchdog_src_int_osc,
   output pmc_mode_type                 mode,
   output pmc_gate_type                 gates,
   output logic                         irq_start,
   output logic                         direct_irq_start,
   output logic                         freq_apply,
   output logic                         periph_reinit_flag
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pmc_mode_type mode_ff;
   pmc_mode_type nxt_mode;
   logic         wake_low_ff;
   logic         nxt_wake_low;
   logic         irq_start_ff;
   logic         nxt_irq_start;
   logic         dir_irq_ff;
   logic         nxt_dir_irq;
   logic         freq_ff;
   logic         nxt_freq;
   logic         reinit_ff;
   logic         nxt_reinit;
   pmc_gate_type gates_ff;
   pmc_gate_type nxt_gates;
   logic         settle_start;
   logic         settle_busy;
   logic         settle_done;
   logic         wake_req;
   logic         running;
   logic         low_mode;

   // wake source is any enabled pending request; pins stay live
   // pins always request
   assign wake_req = irq_pending | (|ext_irq_inputs) | (|wakeup_inputs);
   assign running  = (mode_ff == PMC_ACTIVE) || (mode_ff == PMC_SUBACTIVE);

   pmc_settle_timer u_settle (
      .clk             (clk),
      .srst            (srst),
      .start           (settle_start),
      .settle_time_sel (settle_time_sel),
      .busy            (settle_busy),
      .done            (settle_done)
   );

   // ----------------------------------------------------------------
   // mode sequencing
   // ----------------------------------------------------------------
   always_comb begin
      nxt_mode      = mode_ff;
      nxt_wake_low  = wake_low_ff;
      nxt_irq_start = 1'b0;
      nxt_dir_irq   = 1'b0;
      nxt_freq      = 1'b0;
      nxt_reinit    = reinit_ff;
      settle_start  = 1'b0;
      unique case (mode_ff)
         PMC_RESET: begin
            nxt_mode   = PMC_ACTIVE;
            nxt_reinit = 1'b0;
         end
         PMC_ACTIVE, PMC_SUBACTIVE: begin
            if (sleep_exec) begin
               // clearing flag only once software reinitialises is not ours
               // reset on subsleep
               if (ctrl.subsleep_sel) begin
                  nxt_reinit = 1'b1;
               end
               if (ctrl.direct_transition_sel && direct_irq_en && !irq_mask) begin
                  if (ctrl.low_speed_sel) begin
                     nxt_mode = PMC_SUBACTIVE;
                  end else if (!ctrl.subsleep_sel) begin
                     nxt_mode = PMC_ACTIVE;
                  end else begin
                     // low-speed select is clear here, so wake returns to full speed
                     nxt_mode     = PMC_SUBSLEEP;
                     nxt_wake_low = 1'b0;
                  end
                  if (nxt_mode != PMC_SUBSLEEP) begin
                     nxt_dir_irq = 1'b1;
                     nxt_freq    = 1'b1;
                  end
               end else if (ctrl.standby_sel && !ctrl.direct_transition_sel) begin
                  nxt_mode     = PMC_STANDBY;
                  nxt_wake_low = 1'b0;
               end else begin
                  nxt_mode     = ctrl.subsleep_sel ? PMC_SUBSLEEP : PMC_SLEEP;
                  nxt_wake_low = ctrl.low_speed_sel;
               end
            end
         end
         PMC_SLEEP, PMC_SUBSLEEP: begin
            if (wake_req && !irq_mask) begin
               nxt_mode      = wake_low_ff ? PMC_SUBACTIVE : PMC_ACTIVE;
               nxt_irq_start = 1'b1;
               nxt_freq      = 1'b1;
            end
         end
         PMC_STANDBY: begin
            if (settle_done) begin
               nxt_mode      = PMC_ACTIVE;
               nxt_irq_start = 1'b1;
               nxt_freq      = 1'b1;
            end else if (wake_req && !irq_mask && !settle_busy) begin
               settle_start = 1'b1;
            end
         end
         default: begin
            nxt_mode = PMC_RESET;
         end
      endcase
      if (!ext_reset_n) begin
         nxt_mode      = PMC_RESET;
         nxt_irq_start = 1'b0;
         nxt_dir_irq   = 1'b0;
         nxt_freq      = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_ff      <= PMC_RESET;
         wake_low_ff  <= 1'b0;
         irq_start_ff <= 1'b0;
         dir_irq_ff   <= 1'b0;
         freq_ff      <= 1'b0;
         reinit_ff    <= 1'b0;
      end else begin
         mode_ff      <= nxt_mode;
         wake_low_ff  <= nxt_wake_low;
         irq_start_ff <= nxt_irq_start;
         dir_irq_ff   <= nxt_dir_irq;
         freq_ff      <= nxt_freq;
         reinit_ff    <= nxt_reinit;
      end
   end

   // ----------------------------------------------------------------
   // per-mode gating
   // ----------------------------------------------------------------
   always_comb begin
      low_mode = (nxt_mode == PMC_SUBACTIVE) || (nxt_mode == PMC_SUBSLEEP)
               || (nxt_mode == PMC_STANDBY);
      nxt_gates = '0;
      nxt_gates.main_osc_en = (nxt_mode == PMC_ACTIVE) || (nxt_mode == PMC_SLEEP)
                            || (nxt_mode == PMC_RESET) || settle_busy || settle_start;
      nxt_gates.sub_osc_en  = 1'b1;
      nxt_gates.cpu_run     = (nxt_mode == PMC_ACTIVE) || (nxt_mode == PMC_SUBACTIVE);
      nxt_gates.ram_access  = nxt_gates.cpu_run;
      nxt_gates.port_hold   = (nxt_mode == PMC_SLEEP) || (nxt_mode == PMC_SUBSLEEP)
                            || (nxt_mode == PMC_STANDBY);
      nxt_gates.port_hiz    = (nxt_mode == PMC_STANDBY);
      nxt_gates.periph_reset = low_mode || (nxt_mode == PMC_RESET);
      nxt_gates.timebase_en = !low_mode || timebase_timekeep_sel;
      nxt_gates.capture_en     = (nxt_mode == PMC_STANDBY) ? 1'b0
                               : (!low_mode || capture_src_sys);
      nxt_gates.capture_on_sub = low_mode && (nxt_mode != PMC_STANDBY) && capture_src_sys;
      nxt_gates.watchdog_en = !low_mode || watchdog_src_int_osc;
      nxt_gates.retained_access = (nxt_mode == PMC_ACTIVE) || (nxt_mode == PMC_SUBACTIVE);
      nxt_gates.irq_inputs_live = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         gates_ff <= '0;
      end else begin
         gates_ff <= nxt_gates;
      end
   end

   assign mode               = mode_ff;
   assign gates              = gates_ff;
   assign irq_start          = irq_start_ff;
   assign direct_irq_start   = dir_irq_ff;
   assign freq_apply         = freq_ff;
   assign periph_reinit_flag = reinit_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_reset_forced;
      @(posedge clk) disable iff (srst) !ext_reset_n |=> mode_ff == PMC_RESET;
   endproperty
   a_reset_forced: assert property (p_reset_forced)
      else $error("external reset did not force reset state");

   property p_sleep_entry;
      @(posedge clk) disable iff (srst)
         running && sleep_exec && ext_reset_n && !ctrl.direct_transition_sel
         && !ctrl.standby_sel && !ctrl.subsleep_sel |=> mode_ff == PMC_SLEEP;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry)
      else $error("sleep mode not entered");

   property p_subsleep_entry;
      @(posedge clk) disable iff (srst)
         running && sleep_exec && ext_reset_n && !ctrl.direct_transition_sel
         && !ctrl.standby_sel && ctrl.subsleep_sel |=> mode_ff == PMC_SUBSLEEP;
   endproperty
   a_subsleep_entry: assert property (p_subsleep_entry)
      else $error("subsleep mode not entered");

   property p_standby_entry;
      @(posedge clk) disable iff (srst)
         running && sleep_exec && ext_reset_n && !ctrl.direct_transition_sel
         && ctrl.standby_sel |=> mode_ff == PMC_STANDBY;
   endproperty
   a_standby_entry: assert property (p_standby_entry)
      else $error("standby mode not entered");

   property p_direct_low;
      @(posedge clk) disable iff (srst)
         running && sleep_exec && ext_reset_n && ctrl.direct_transition_sel
         && ctrl.low_speed_sel && direct_irq_en && !irq_mask
         |=> mode_ff == PMC_SUBACTIVE && direct_irq_start;
   endproperty
   a_direct_low: assert property (p_direct_low)
      else $error("direct move to low speed failed");

   property p_masked_hold;
      @(posedge clk) disable iff (srst)
         (mode_ff == PMC_SLEEP || mode_ff == PMC_SUBSLEEP) && irq_mask && ext_reset_n
         |=> $stable(mode_ff);
   endproperty
   a_masked_hold: assert property (p_masked_hold)
      else $error("masked interrupt cleared halted mode");

   property p_osc_gate;
      @(posedge clk) disable iff (srst)
         mode_ff == PMC_SUBACTIVE && $past(mode_ff) == PMC_SUBACTIVE
         |-> !gates_ff.main_osc_en && gates_ff.sub_osc_en;
   endproperty
   a_osc_gate: assert property (p_osc_gate)
      else $error("main oscillator running in low speed");

   property p_standby_hiz;
      @(posedge clk) disable iff (srst)
         mode_ff == PMC_STANDBY && $past(mode_ff) == PMC_STANDBY
         |-> gates_ff.port_hiz && gates_ff.periph_reset;
   endproperty
   a_standby_hiz: assert property (p_standby_hiz)
      else $error("ports not floated in standby");

   property p_standby_wake;
      @(posedge clk) disable iff (srst)
         mode_ff == PMC_STANDBY && $rose(settle_busy) ##1 settle_busy[*2]
         |-> mode_ff == PMC_STANDBY;
   endproperty
   a_standby_wake: assert property (p_standby_wake)
      else $error("standby left before settling");

   property p_wake_halted;
      @(posedge clk) disable iff (srst)
         (mode_ff == PMC_SLEEP || mode_ff == PMC_SUBSLEEP) && wake_req && !irq_mask
         && ext_reset_n |=> running && irq_start && freq_apply;
   endproperty
   a_wake_halted: assert property (p_wake_halted)
      else $error("halted mode not left on wake");

   property p_direct_full;
      @(posedge clk) disable iff (srst)
         running && sleep_exec && ext_reset_n && ctrl.direct_transition_sel
         && !ctrl.subsleep_sel && !ctrl.low_speed_sel && direct_irq_en && !irq_mask
         |=> mode_ff == PMC_ACTIVE && direct_irq_start && freq_apply;
   endproperty
   a_direct_full: assert property (p_direct_full)
      else $error("direct move to full speed failed");

   c_sleep_wake: cover property (@(posedge clk) disable iff (srst)
      mode_ff == PMC_SLEEP ##1 irq_start);
   c_standby_wake: cover property (@(posedge clk) disable iff (srst)
      mode_ff == PMC_STANDBY ##1 mode_ff == PMC_ACTIVE);
   c_direct: cover property (@(posedge clk) disable iff (srst) direct_irq_start);
   c_subsleep_wake: cover property (@(posedge clk) disable iff (srst)
      mode_ff == PMC_SUBSLEEP ##1 irq_start);
   c_masked: cover property (@(posedge clk) disable iff (srst)
      mode_ff == PMC_SLEEP && irq_mask && wake_req);

endmodule

//--- testbench/pmc_irq_src_model.sv
// partner model: interrupt source raising requests and withdrawing them once taken
module pmc_irq_src_model
   import pmc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       raise,
   input  wire logic [3:0] lat,
   input  wire logic       irq_start,
   output logic            irq_pending
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] wait_ff;
   logic       acked_ff;

   // ----------------------------------------------------------------
   // request source
   // ----------------------------------------------------------------
   // lat sets prompt or slow requests; re-arms only after raise drops
   always_ff @(posedge clk) begin
      if (srst || !raise) begin
         wait_ff     <= 4'h0;
         acked_ff    <= 1'b0;
         irq_pending <= 1'b0;
      end else if (irq_start) begin
         acked_ff    <= 1'b1;
         irq_pending <= 1'b0;
      end else if (!acked_ff) begin
         if (wait_ff >= lat) begin
            irq_pending <= 1'b1;
         end else begin
            wait_ff <= wait_ff + 4'h1;
         end
      end
   end
endmodule

//--- testbench/pmc_top_tb_top.sv
// testbench: sleep decode, wake, direct transitions, gating and external reset
module pmc_top_tb_top;
   import pmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic                    clk = 1'b0;
   logic                    srst = 1'b1;
   logic                    ext_reset_n = 1'b1;
   logic                    sleep_exec = 1'b0;
   pmc_ctrl_type            ctrl = '0;
   logic                    irq_mask = 1'b0;
   logic                    irq_pending;
   logic                    direct_irq_en = 1'b1;
   logic [PMC_IRQ_W-1:0]    ext_irq_inputs = 4'h0;
   logic [PMC_WKP_W-1:0]    wakeup_inputs = 6'h00;
   logic                    tk_sel = 1'b1;
   logic                    cap_sys = 1'b1;
   logic                    wd_int = 1'b0;
   logic                    raise = 1'b0;
   logic [3:0]              lat = 4'h0;
   pmc_mode_type            mode;
   pmc_gate_type            gates;
   logic                    irq_start;
   logic                    direct_irq_start;
   logic                    freq_apply;
   logic                    periph_reinit_flag;
   int                      failures = 0;
   int                      tests_run = 0;
   int                      wake_cycles;
   int                      wake_exp;
   pmc_ctrl_type            c;
   pmc_mode_type            es;
   pmc_mode_type            ew;

   always #20 clk = ~clk;

   pmc_top uut (.clk(clk), .srst(srst), .ext_reset_n(ext_reset_n), .sleep_exec(sleep_exec),
      .ctrl(ctrl), .settle_time_sel(3'h7), .irq_mask(irq_mask), .irq_pending(irq_pending),
      .direct_irq_en(direct_irq_en), .ext_irq_inputs(ext_irq_inputs),
      .wakeup_inputs(wakeup_inputs), .timebase_timekeep_sel(tk_sel),
      .capture_src_sys(cap_sys), .watchdog_src_int_osc(wd_int), .mode(mode), .gates(gates),
      .irq_start(irq_start), .direct_irq_start(direct_irq_start), .freq_apply(freq_apply),
      .periph_reinit_flag(periph_reinit_flag));

   pmc_irq_src_model partner (.clk(clk), .srst(srst), .raise(raise), .lat(lat),
      .irq_start(irq_start), .irq_pending(irq_pending));

   // ----------------------------------------------------------------
   // compare tasks
   // ----------------------------------------------------------------
   task automatic report(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      report({15'h0000, got}, {15'h0000, exp});
   endtask

   task automatic chk_mode(input pmc_mode_type exp);
      report({10'h000, mode}, {10'h000, exp});
   endtask

   // gate expectation built from the mode table, options as currently driven
   task automatic chk_gates(input pmc_mode_type m);
      pmc_gate_type g;
      logic         lo;
      logic         halt;
      lo = (m == PMC_SUBACTIVE) || (m == PMC_SUBSLEEP) || (m == PMC_STANDBY);
      halt = (m == PMC_SLEEP) || (m == PMC_SUBSLEEP) || (m == PMC_STANDBY);
      g = '0;
      g.main_osc_en = !lo;
      g.sub_osc_en = 1'b1;
      g.cpu_run = (m == PMC_ACTIVE) || (m == PMC_SUBACTIVE);
      g.ram_access = g.cpu_run;
      g.port_hold = halt;
      g.port_hiz = (m == PMC_STANDBY);
      g.periph_reset = lo || (m == PMC_RESET);
      g.timebase_en = !lo || tk_sel;
      g.capture_en = (m != PMC_STANDBY) && (!lo || cap_sys);
      g.capture_on_sub = lo && (m != PMC_STANDBY) && cap_sys;
      g.watchdog_en = !lo || wd_int;
      g.retained_access = g.cpu_run;
      g.irq_inputs_live = 1'b1;
      report({3'h0, gates}, {3'h0, g});
   endtask

   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic do_sleep(input pmc_ctrl_type cv, input pmc_mode_type em, input logic dir);
      @(posedge clk);
      ctrl <= cv;
      sleep_exec <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0;
      #1;
      chk_mode(em);
      chk_gates(em);
      chk_bit(direct_irq_start, dir);
      chk_bit(freq_apply, dir);
   endtask

   // src 0: partner request, 1: external irq pin, 2: wakeup pin
   task automatic wake(input int src, input pmc_mode_type em);
      int n;
      n = 0;
      @(posedge clk);
      irq_mask <= 1'b0;
      raise <= (src == 0);
      ext_irq_inputs <= (src == 1) ? 4'h1 : 4'h0;
      wakeup_inputs <= (src == 2) ? 6'h20 : 6'h00;
      while (irq_start !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      wake_cycles = n;
      chk_bit(irq_start, 1'b1);
      chk_bit(freq_apply, 1'b1);
      chk_mode(em);
      chk_gates(em);
      @(posedge clk);
      raise <= 1'b0;
      ext_irq_inputs <= 4'h0;
      wakeup_inputs <= 6'h00;
      #1;
      chk_bit(irq_start, 1'b0);
   endtask

   task automatic end_test(input string name);
      $display("test %s done, %0d mismatches so far", name, failures);
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      chk_mode(PMC_ACTIVE);
      chk_bit(periph_reinit_flag, 1'b0);
      end_test("reset");
      for (int i = 0; i < 8; i++) begin
         c = pmc_ctrl_type'(i[3:0]);
         es = c.standby_sel ? PMC_STANDBY : (c.subsleep_sel ? PMC_SUBSLEEP : PMC_SLEEP);
         ew = (c.low_speed_sel && !c.standby_sel) ? PMC_SUBACTIVE : PMC_ACTIVE;
         lat <= 4'(i % 4);
         do_sleep(c, es, 1'b0);
         wake(i % 3, ew);
         // request latency, then the settle count and one more edge in standby
         wake_exp = ((i % 3 == 0) ? (i % 4) + 2 : 1)
                  + ((es == PMC_STANDBY) ? int'(PMC_SETTLE_7) + 1 : 0);
         report(16'(wake_cycles), 16'(wake_exp));
      end
      chk_bit(periph_reinit_flag, 1'b1);
      end_test("sleep table");
      do_sleep(4'b1000, PMC_ACTIVE, 1'b1);
      do_sleep(4'b1001, PMC_SUBACTIVE, 1'b1);
      do_sleep(4'b1111, PMC_SUBACTIVE, 1'b1);
      do_sleep(4'b1000, PMC_ACTIVE, 1'b1);
      do_sleep(4'b1100, PMC_ACTIVE, 1'b1);
      end_test("direct");
      @(posedge clk);
      direct_irq_en <= 1'b0;
      do_sleep(4'b1000, PMC_SLEEP, 1'b0);
      wake(0, PMC_ACTIVE);
      @(posedge clk);
      direct_irq_en <= 1'b1;
      irq_mask <= 1'b1;
      do_sleep(4'b1001, PMC_SLEEP, 1'b0);
      wake(1, PMC_SUBACTIVE);
      do_sleep(4'b1010, PMC_SUBSLEEP, 1'b0);
      wake(2, PMC_ACTIVE);
      end_test("direct refused");
      do_sleep(4'b0000, PMC_SLEEP, 1'b0);
      @(posedge clk);
      irq_mask <= 1'b1;
      raise <= 1'b1;
      wakeup_inputs <= 6'h01;
      repeat (10) @(posedge clk);
      #1;
      chk_mode(PMC_SLEEP);
      chk_bit(irq_start, 1'b0);
      wake(0, PMC_ACTIVE);
      end_test("masked wake");
      @(posedge clk);
      tk_sel <= 1'b0;
      wd_int <= 1'b1;
      cap_sys <= 1'b0;
      do_sleep(4'b1001, PMC_SUBACTIVE, 1'b1);
      do_sleep(4'b0011, PMC_SUBSLEEP, 1'b0);
      wake(2, PMC_SUBACTIVE);
      end_test("options");
      @(posedge clk);
      ext_reset_n <= 1'b0;
      @(posedge clk);
      #1;
      chk_mode(PMC_RESET);
      repeat (3) @(posedge clk);
      #1;
      chk_mode(PMC_RESET);
      chk_bit(periph_reinit_flag, 1'b0);
      chk_gates(PMC_RESET);
      @(posedge clk);
      ext_reset_n <= 1'b1;
      @(posedge clk);
      #1;
      chk_mode(PMC_ACTIVE);
      end_test("external reset");
      test_done();
   end

   initial begin
      #100000;
      failures++;
      test_done();
   end
endmodule
